//--- adcsq_defs.vh
// How it works
// - channel-tag bit set: channel in result low nibble, else bits 19..16
// - dma on: request each conversion end, irq only after dma done
// - sample window is 2 plus extension clocks; all ones holds switch closed
// - sequence length field plus one gives conversions per sequence
// - single mode with nonzero length: each trigger advances step number
// - auto-restart 0 halts at sequence end, 1 restarts automatically
// - mode 00 single/continuous, 01 sequenced, 10 and 11 reserved
// - trigger group: 00 software only, 01 timers, 10 pwm0, 11 pwm1
// - sequenced mode: channel per step, starting at step zero unless written
// - event triggering converts step n only on its own trigger source
// - writing step number while idle redirects next conversion to it
// - active channel readable as a 4-bit code
// - internal clock: system clock divided; 0 passes through, 1 stops
// - power-down bit resets to 1 and blocks conversion until cleared
// - clock-source bit 0 internal divider, 1 external clock enable
// - step trigger code picks timer or pwm point, bottom, period
// - stop bit requests halt, self-clears, running conversion completes
// - start bit begins conversion when enabled and self-clears
// - event mode without restart runs the sequence once then halts
// - sequence done flag set on final conversion, write 1 clears
// - trigger flag set on triggered conversion, write 1 clears
// - per-flag enables gate the interrupt requests
// - one conversion is 15 converter clocks, longer with extension
// - dma word holds result in bits 15..4, channel in low nibble only with tag bit set
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH
`define ADCSQ_OFF_MODE    32'h4000b000
`define ADCSQ_OFF_CUR     32'h4000b004
`define ADCSQ_OFF_CLK     32'h4000b008
`define ADCSQ_OFF_TRG     32'h4000b00c
`define ADCSQ_OFF_CHSEL   32'h4000b018
`define ADCSQ_OFF_CTRL    32'h4000b020
`define ADCSQ_OFF_STAT    32'h4000b024
`define ADCSQ_OFF_IEN     32'h4000b028
`define ADCSQ_OFF_DMA     32'h4000b02c
`define ADCSQ_CLK_RESET   16'h0080
`define ADCSQ_MODE_SINGLE 2'h0
`define ADCSQ_MODE_SEQ    2'h1
`define ADCSQ_TG_SOFT     2'h0
`define ADCSQ_TG_TIMER    2'h1
`define ADCSQ_TG_PWM0     2'h2
`define ADCSQ_TG_PWM1     2'h3
`define ADCSQ_ST_ALWAYS   5'h1f
`define ADCSQ_SAMPLE_MIN  9'h002
`define ADCSQ_RES_BITS    9'h00c
`define ADCSQ_BIT_DONE    2
`define ADCSQ_BIT_TRG     3
`define ADCSQ_BIT_DMA     4
`endif

//--- adcsq_control.v
`include "adcsq_defs.vh"
`default_nettype none
module adcsq_control (
    input  wire        clock,
    input  wire        rst,
    input  wire [31:0] busAddr,
    input  wire [31:0] busWdata,
    input  wire        busWr,
    input  wire        busRd,
    output reg  [31:0] busRdata_r,
    input  wire [5:0]  timerEvt,
    input  wire [7:0]  pwm0Evt,
    input  wire [7:0]  pwm1Evt,
    input  wire        extClkTick,
    input  wire        coreBit,
    output reg  [3:0]  coreChannel_r,
    output reg         coreSample_r,
    output reg         coreConvert_r,
    output reg         corePowerDown_r,
    output reg         dmaReq_r,
    input  wire        dmaDone,
    output reg  [31:0] dmaWord_r,
    output reg         irq_r
);
    // state codes
    localparam ST_IDLE   = 2'h0;
    localparam ST_START  = 2'h1;
    localparam ST_SAMPLE = 2'h2;
    localparam ST_BITS   = 2'h3;

    reg [31:0] modeReg_r;
    reg [15:0] clkReg_r;
    reg [31:0] trgReg_r;
    reg [31:0] chReg_r;
    reg [4:0]  ienReg_r;
    reg [2:0]  step_r;
    reg [3:0]  active_r;
    reg        goReq_r;
    reg        haltReq_r;
    reg        haltPend_r; // stop seen while busy, applied at conversion end
    reg        armed_r;
    reg        doneFlag_r;
    reg        trgFlag_r;
    reg        dmaFlag_r;
    reg        dmaWait_r;
    reg [1:0]  state_r;
    reg [8:0]  cnt_r;
    reg [11:0] result_r;
    reg [6:0]  divCnt_r;
    reg        tick_r;
    reg [21:0] evtQ1_r;
    reg [21:0] evtQ2_r;
    reg [21:0] evtQ3_r;
    reg [21:0] evtLvl_r;
    reg [21:0] evtPrev_r;
    reg        extQ1_r;
    reg        extQ2_r;
    reg        extQ3_r;
    reg        extLvl_r;
    reg        extPrev_r;

    wire [1:0] trgGroup = modeReg_r[1:0];
    wire [1:0] convMode = modeReg_r[5:4];
    wire       autoRst  = modeReg_r[6];
    wire       convEn   = modeReg_r[7];
    wire [2:0] seqLen   = modeReg_r[10:8];
    wire [4:0] stExt    = modeReg_r[16:12];
    wire       dma_request_enable    = modeReg_r[17];
    wire       tagLow   = modeReg_r[18];
    wire [6:0] divVal   = clkReg_r[14:8];
    wire       powerDn  = clkReg_r[7];
    wire       extSel   = clkReg_r[6];
    wire       busy     = (state_r != ST_IDLE);
    wire       wrMode   = busWr && (busAddr == `ADCSQ_OFF_MODE);
    wire       wrCur    = busWr && (busAddr == `ADCSQ_OFF_CUR);
    wire       wrCtrl   = busWr && (busAddr == `ADCSQ_OFF_CTRL);
    wire       wrStat   = busWr && (busAddr == `ADCSQ_OFF_STAT);

    // pick one trigger line from group and code
    function trgPick;
        input [1:0]  grp;
        input [2:0]  code;
        input [21:0] ev;
        begin
            case (grp)
                `ADCSQ_TG_TIMER: trgPick = (code < 3'h6) ? ev[code] : 1'b0;
                `ADCSQ_TG_PWM0:  trgPick = ev[6 + code];
                `ADCSQ_TG_PWM1:  trgPick = ev[14 + code];
                default:         trgPick = 1'b0;
            endcase
        end
    endfunction

    // external event pins: three flops, change counts when q2 and q3 agree
    always @(posedge clock) begin
        if (rst) begin
            evtQ1_r   <= 22'h0;
            evtQ2_r   <= 22'h0;
            evtQ3_r   <= 22'h0;
            evtLvl_r  <= 22'h0;
            evtPrev_r <= 22'h0;
            extQ1_r   <= 1'b0;
            extQ2_r   <= 1'b0;
            extQ3_r   <= 1'b0;
            extLvl_r  <= 1'b0;
            extPrev_r <= 1'b0;
        end else begin
            evtQ1_r   <= {pwm1Evt, pwm0Evt, timerEvt};
            evtQ2_r   <= evtQ1_r;
            evtQ3_r   <= evtQ2_r;
            evtLvl_r  <= (evtQ2_r & evtQ3_r) | (evtLvl_r & (evtQ2_r | evtQ3_r));
            evtPrev_r <= evtLvl_r;
            extQ1_r   <= extClkTick;
            extQ2_r   <= extQ1_r;
            extQ3_r   <= extQ2_r;
            extLvl_r  <= (extQ2_r & extQ3_r) | (extLvl_r & (extQ2_r | extQ3_r));
            extPrev_r <= extLvl_r;
        end
    end

    wire [21:0] evtRise = evtLvl_r & ~evtPrev_r;
    wire        stepTrg = trgPick(trgGroup, trgReg_r[{step_r, 2'b00} +: 3], evtRise);

    // converter clock enable; a clock-enable pulse stands in for the divided clock
    always @(posedge clock) begin
        if (rst) begin
            divCnt_r <= 7'h0;
            tick_r   <= 1'b0;
        end else if (extSel) begin
            tick_r   <= extLvl_r & ~extPrev_r;
            divCnt_r <= 7'h0;
        end else if (divVal == 7'h0) begin
            // zero passes clock, one stops it
            tick_r   <= 1'b1;
            divCnt_r <= 7'h0;
        end else if (divVal == 7'h1) begin
            tick_r   <= 1'b0;
            divCnt_r <= 7'h0;
        end else if (divCnt_r >= divVal - 7'h1) begin
            tick_r   <= 1'b1;
            divCnt_r <= 7'h0;
        end else begin
            tick_r   <= 1'b0;
            divCnt_r <= divCnt_r + 7'h1;
        end
    end

    // a conversion may begin: software start, or its step event when armed
    wire evtMode   = (trgGroup != `ADCSQ_TG_SOFT);
    wire canConv   = convEn && !powerDn;
    wire launchSw  = goReq_r && !evtMode;
    wire launchEvt = armed_r && evtMode && stepTrg;
    wire lastStep  = (convMode == `ADCSQ_MODE_SEQ || seqLen != 3'h0) ? (step_r == seqLen) : 1'b1;

    // sequencer and conversion timing
    always @(posedge clock) begin
        if (rst) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 9'h0;
            step_r        <= 3'h0;
            active_r      <= 4'h0;
            armed_r       <= 1'b0;
            goReq_r       <= 1'b0;
            haltReq_r     <= 1'b0;
            haltPend_r    <= 1'b0;
            result_r      <= 12'h0;
            coreSample_r  <= 1'b0;
            coreConvert_r <= 1'b0;
        end else begin
            if (wrCur && !busy) step_r <= busWdata[6:4];
            if (wrCtrl && busWdata[0] && convEn) goReq_r <= 1'b1;
            else if (tick_r) goReq_r <= 1'b0;
            if (wrCtrl && busWdata[7]) haltReq_r <= 1'b1;
            else if (tick_r) haltReq_r <= 1'b0;
            if (goReq_r && evtMode && tick_r) armed_r <= 1'b1;
            if (haltReq_r && tick_r) armed_r <= 1'b0;
            // stop bit clears in one tick, so remember it until the end
            if (haltReq_r && tick_r && busy) haltPend_r <= 1'b1;
            // switch held closed at all ones
            coreSample_r <= canConv && (stExt == `ADCSQ_ST_ALWAYS || state_r == ST_SAMPLE);
            coreConvert_r <= (state_r == ST_BITS);
            if (tick_r) begin
                case (state_r)
                    ST_IDLE: begin
                        if (canConv && !haltReq_r && (launchSw || launchEvt)) begin
                            active_r <= chReg_r[{step_r, 2'b00} +: 4];
                            state_r  <= ST_START;
                        end
                    end
                    ST_START: begin
                        cnt_r   <= `ADCSQ_SAMPLE_MIN + {4'h0, stExt} - 9'h1;
                        state_r <= ST_SAMPLE;
                    end
                    ST_SAMPLE: begin
                        if (cnt_r == 9'h0) begin
                            cnt_r   <= `ADCSQ_RES_BITS - 9'h1;
                            state_r <= ST_BITS;
                        end else begin
                            cnt_r <= cnt_r - 9'h1;
                        end
                    end
                    ST_BITS: begin
                        result_r <= {result_r[10:0], coreBit};
                        if (cnt_r == 9'h0) begin
                            state_r    <= ST_IDLE;
                            haltPend_r <= 1'b0;
                            if (lastStep) begin
                                step_r <= 3'h0;
                                // restart or halt at sequence end
                                if (!autoRst || haltReq_r || haltPend_r) begin
                                    armed_r <= 1'b0;
                                    goReq_r <= 1'b0;
                                end else if (!evtMode) begin
                                    goReq_r <= 1'b1;
                                end
                            end else begin
                                step_r <= step_r + 3'h1;
                                if (!evtMode && !haltReq_r && !haltPend_r) goReq_r <= 1'b1;
                            end
                        end else begin
                            cnt_r <= cnt_r - 9'h1;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // end of conversion: last result bit shifted this tick
    wire eoc = tick_r && (state_r == ST_BITS) && (cnt_r == 9'h0);
    wire [11:0] finalRes = {result_r[10:0], coreBit};

    // flags, dma handoff and interrupt
    always @(posedge clock) begin
        if (rst) begin
            doneFlag_r      <= 1'b0;
            trgFlag_r       <= 1'b0;
            dmaFlag_r       <= 1'b0;
            dmaWait_r       <= 1'b0;
            dmaReq_r        <= 1'b0;
            dmaWord_r       <= 32'h0;
            irq_r           <= 1'b0;
            coreChannel_r   <= 4'h0;
            corePowerDown_r <= 1'b1;
        end else begin
            coreChannel_r   <= active_r;
            corePowerDown_r <= powerDn;
            dmaReq_r        <= dma_request_enable && eoc;
            if (dma_request_enable && eoc) begin
                dmaWord_r <= tagLow ? {16'h0, finalRes, active_r}
                                    : {12'h0, active_r, finalRes, 4'h0};
            end
            // set beats clear on every flag
            // sequence done flag
            doneFlag_r <= (eoc && lastStep) ||
                          (doneFlag_r && !(wrStat && busWdata[`ADCSQ_BIT_DONE]));
            trgFlag_r  <= (eoc && evtMode) ||
                          (trgFlag_r && !(wrStat && busWdata[`ADCSQ_BIT_TRG]));
            if (dma_request_enable && eoc) dmaWait_r <= 1'b1;
            else if (dmaDone) dmaWait_r <= 1'b0;
            dmaFlag_r  <= (dmaWait_r && dmaDone) ||
                          (dmaFlag_r && !(wrStat && busWdata[`ADCSQ_BIT_DMA]));
            irq_r <= (dmaFlag_r && ienReg_r[`ADCSQ_BIT_DMA]) ||
                     (trgFlag_r && ienReg_r[`ADCSQ_BIT_TRG] && !dma_request_enable) ||
                     (doneFlag_r && ienReg_r[`ADCSQ_BIT_DONE] && !dma_request_enable);
        end
    end

    // register writes
    always @(posedge clock) begin
        if (rst) begin
            modeReg_r <= 32'h0;
            clkReg_r  <= `ADCSQ_CLK_RESET;
            trgReg_r  <= 32'h0;
            chReg_r   <= 32'h0;
            ienReg_r  <= 5'h0;
        end else if (busWr) begin
            // mode and group fields stored as written
            if (busAddr == `ADCSQ_OFF_MODE)  modeReg_r <= busWdata & 32'h0007f7f3;
            if (busAddr == `ADCSQ_OFF_CLK)   clkReg_r  <= busWdata[15:0] & 16'hffe0;
            if (busAddr == `ADCSQ_OFF_TRG)   trgReg_r  <= busWdata & 32'h77777777;
            if (busAddr == `ADCSQ_OFF_CHSEL) chReg_r   <= busWdata;
            if (busAddr == `ADCSQ_OFF_IEN)   ienReg_r  <= busWdata[4:0] & 5'h1d;
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always @(posedge clock) begin
        if (rst) begin
            busRdata_r <= 32'h0;
        end else if (busRd) begin
            case (busAddr)
                `ADCSQ_OFF_MODE:  busRdata_r <= modeReg_r;
                `ADCSQ_OFF_CUR:   busRdata_r <= {25'h0, step_r, active_r};
                `ADCSQ_OFF_CLK:   busRdata_r <= {16'h0, clkReg_r};
                `ADCSQ_OFF_TRG:   busRdata_r <= trgReg_r;
                `ADCSQ_OFF_CHSEL: busRdata_r <= chReg_r;
                `ADCSQ_OFF_CTRL:  busRdata_r <= {31'h0, goReq_r};
                `ADCSQ_OFF_STAT:  busRdata_r <= {25'h0, busy, 1'b0, dmaFlag_r,
                                                 trgFlag_r, doneFlag_r, 2'h0};
                `ADCSQ_OFF_IEN:   busRdata_r <= {27'h0, ienReg_r};
                `ADCSQ_OFF_DMA:   busRdata_r <= dmaWord_r;
                default:          busRdata_r <= 32'h0;
            endcase
        end else begin
            busRdata_r <= 32'h0;
        end
    end
endmodule
`default_nettype wire

//--- adcsq_control_asserts.sv
`default_nettype none
// watches the top-level ports only; all checks share one clock and the reset
module adcsq_control_asserts (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        busRd,
    input wire logic [31:0] busRdata_r,
    input wire logic [3:0]  coreChannel_r,
    input wire logic        coreSample_r,
    input wire logic        coreConvert_r,
    input wire logic        corePowerDown_r,
    input wire logic        dmaReq_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // sample window of two ticks precedes the bit phase
    sequence s_sampled;
        $past(coreSample_r, 2) && $past(coreSample_r, 1);
    endsequence
    // twelve bit ticks: at least eight clocks in a row
    sequence s_bitrun;
        coreConvert_r [*8];
    endsequence
    property p_rst_state;
        $fell(rst) |-> corePowerDown_r && !dmaReq_r && !coreConvert_r;
    endproperty
    property p_rd_idle;
        !$past(busRd) |-> busRdata_r == 32'h0;
    endproperty
    property p_sample_first;
        $rose(coreConvert_r) |-> s_sampled;
    endproperty
    property p_bits_run;
        $rose(coreConvert_r) |-> s_bitrun;
    endproperty
    property p_chan_hold;
        coreConvert_r && $past(coreConvert_r) |-> $stable(coreChannel_r);
    endproperty
    property p_pd_block;
        $rose(coreConvert_r) |-> !corePowerDown_r;
    endproperty
    property p_dma_after_bits;
        $rose(dmaReq_r) |-> $past(coreConvert_r, 1) || $past(coreConvert_r, 2)
            || $past(coreConvert_r, 3);
    endproperty
    property p_dma_pulse;
        dmaReq_r |=> !dmaReq_r;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("power-down not set after reset");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the read cycle");
    a_sample_first: assert property (p_sample_first)
        else $error("bit phase without two sample clocks");
    a_bits_run: assert property (p_bits_run)
        else $error("bit phase cut short");
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel changed during bit phase");
    a_pd_block: assert property (p_pd_block)
        else $error("conversion while powered down");
    a_dma_after_bits: assert property (p_dma_after_bits)
        else $error("dma request without end of conversion");
    a_dma_pulse: assert property (p_dma_pulse)
        else $error("dma request longer than one cycle");
endmodule
bind adcsq_control adcsq_control_asserts u_chk (
    .clock(clock), .rst(rst), .busRd(busRd), .busRdata_r(busRdata_r),
    .coreChannel_r(coreChannel_r), .coreSample_r(coreSample_r),
    .coreConvert_r(coreConvert_r), .corePowerDown_r(corePowerDown_r), .dmaReq_r(dmaReq_r));
`default_nettype wire

//--- adcsq_core_model.sv
`default_nettype none
// analog core stand-in: result is all ones on odd channels, all zeros on even
module adcsq_core_model (
    input  wire logic       clock,
    input  wire logic [3:0] coreChannel_r,
    input  wire logic       coreSample_r,
    input  wire logic       coreConvert_r,
    input  wire logic       corePowerDown_r,
    output var  logic       coreBit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial coreBit = 1'b0;
    // one bit per clock
    // held from sampling on, so a tick misalignment cannot change the word
    always @(posedge clock) begin
        if ((coreSample_r || coreConvert_r) && !corePowerDown_r) begin
            coreBit <= coreChannel_r[0];
        end else begin
            coreBit <= ~coreBit; // idle line toggles, never a stale value
        end
    end
endmodule
`default_nettype wire

//--- adcsq_control_test.sv
`include "adcsq_defs.vh"
`default_nettype none
// one compare: counts it and reports a miss at once
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module adcsq_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] busAddr = 32'h0;
    logic [31:0] busWdata = 32'h0;
    logic        busWr = 1'b0;
    logic        busRd = 1'b0;
    logic        dmaDone = 1'b0;
    logic [7:0]  ev = 8'h0;
    logic [1:0]  grp = 2'h0;
    logic [31:0] d;
    logic [3:0]  firstCh;
    logic [3:0]  lastCh;
    logic        convPrev = 1'b0;
    wire  logic [31:0] busRdata_r;
    wire  logic [31:0] dmaWord_r;
    wire  logic [3:0]  coreChannel_r;
    wire  logic        coreBit, coreSample_r, coreConvert_r, corePowerDown_r, dmaReq_r, irq_r;
    int err_count = 0;
    int comparisons = 0;
    int convCount = 0;
    int cyc = 0;
    always #20 clock = ~clock;
    adcsq_control dut (.clock(clock), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata_r(busRdata_r),
        .timerEvt(grp == 2'h1 ? ev[5:0] : 6'h0), .pwm0Evt(grp == 2'h2 ? ev : 8'h0),
        .pwm1Evt(grp == 2'h3 ? ev : 8'h0), .extClkTick(1'b0), .coreBit(coreBit),
        .coreChannel_r(coreChannel_r), .coreSample_r(coreSample_r),
        .coreConvert_r(coreConvert_r), .corePowerDown_r(corePowerDown_r),
        .dmaReq_r(dmaReq_r), .dmaDone(dmaDone), .dmaWord_r(dmaWord_r), .irq_r(irq_r));
    adcsq_core_model core (.clock(clock), .coreChannel_r(coreChannel_r),
        .coreSample_r(coreSample_r), .coreConvert_r(coreConvert_r),
        .corePowerDown_r(corePowerDown_r), .coreBit(coreBit));
    // conversion monitor: counts bit phases and records channels
    always @(posedge clock) begin
        convPrev <= coreConvert_r;
        if (coreConvert_r && !convPrev) begin
            if (convCount == 0) firstCh = coreChannel_r;
            lastCh = coreChannel_r;
            convCount++;
        end
    end
    // hang guard, well above the longest expected run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock);
        busAddr <= a;
        busWdata <= v;
        busWr <= 1'b1;
        @(posedge clock);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clock);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clock);
        busRd <= 1'b0;
        #1 v = busRdata_r;
    endtask
    task automatic go();
        convCount = 0;
        wr(`ADCSQ_OFF_CTRL, 32'h1);
    endtask
    task automatic waitDma(output int n);
        for (n = 0; n < 3000 && dmaReq_r !== 1'b1; n++) @(posedge clock) #1;
    endtask
    // busy only settles a few clocks after the start write
    task automatic waitIdle();
        repeat (4) @(posedge clock);
        d = 32'h40;
        for (int k = 0; k < 300 && d[6] !== 1'b0; k++) rd(`ADCSQ_OFF_STAT, d);
    endtask
    task automatic pulse(input int b);
        @(posedge clock);
        ev[b] <= 1'b1;
        repeat (2) @(posedge clock);
        ev[b] <= 1'b0;
    endtask
    task automatic dmaAck();
        @(posedge clock);
        dmaDone <= 1'b1;
        @(posedge clock);
        dmaDone <= 1'b0;
        repeat (3) @(posedge clock) #1;
    endtask
    task automatic t_reset();
        rd(`ADCSQ_OFF_CLK, d);
        `CHK("clkReset", 32'h00000080, d)
        `CHK("powerDown", 1'b1, corePowerDown_r)
        rd(32'h4000b010, d);
        `CHK("unmapped", 32'h0, d)
        wr(`ADCSQ_OFF_CLK, 32'h0);
        @(posedge clock) #1;
        `CHK("powerUp", 1'b0, corePowerDown_r)
    endtask
    task automatic t_dma();
        int n0, n;
        wr(`ADCSQ_OFF_IEN, 32'h1c);
        wr(`ADCSQ_OFF_MODE, 32'h20080);
        wr(`ADCSQ_OFF_CHSEL, 32'h5);
        go();
        waitDma(n0);
        `CHK("latency", 16, n0)
        repeat (3) @(posedge clock) #1;
        `CHK("wordHigh", 32'h0005fff0, dmaWord_r)
        `CHK("irqHeld", 1'b0, irq_r)
        dmaAck();
        `CHK("irqDma", 1'b1, irq_r)
        wr(`ADCSQ_OFF_STAT, 32'h1c);
        wr(`ADCSQ_OFF_MODE, 32'h63080); // tag low, extension 3
        wr(`ADCSQ_OFF_CHSEL, 32'h4);
        go();
        waitDma(n);
        `CHK("extension", n0 + 3, n)
        repeat (3) @(posedge clock) #1;
        `CHK("wordLow", 32'h00000004, dmaWord_r)
        dmaAck();
        wr(`ADCSQ_OFF_STAT, 32'h1c);
        // irq is registered from the flags: one more clock after the clear
        @(posedge clock) #1;
        `CHK("irqClear", 1'b0, irq_r)
    endtask
    task automatic t_seq(input int len);
        wr(`ADCSQ_OFF_MODE, 32'h90 | (len << 8));
        wr(`ADCSQ_OFF_CHSEL, 32'hfedcba98);
        go();
        waitIdle();
        `CHK("seqDone", 1'b1, d[2])
        `CHK("firstCh", 4'h8, firstCh)
        `CHK("lastCh", 4'(8 + len), lastCh)
        repeat (60) @(posedge clock) #1;
        `CHK("seqCount", len + 1, convCount)
        `CHK("irqSeq", 1'b1, irq_r)
        wr(`ADCSQ_OFF_STAT, 32'h1c);
    endtask
    task automatic t_redirect();
        wr(`ADCSQ_OFF_MODE, 32'h390);
        wr(`ADCSQ_OFF_CUR, 32'h20);
        wr(`ADCSQ_OFF_CHSEL, 32'hfedcba98);
        go();
        waitIdle();
        `CHK("skipCount", 2, convCount)
        `CHK("skipCh", 4'ha, firstCh)
        wr(`ADCSQ_OFF_STAT, 32'h1c);
    endtask
    task automatic t_events();
        for (int g = 1; g < 4; g++) begin
            grp <= 2'(g);
            wr(`ADCSQ_OFF_MODE, 32'h90 | g);
            wr(`ADCSQ_OFF_TRG, 32'h5);
            wr(`ADCSQ_OFF_CHSEL, 32'h0);
            go();
            pulse(4);
            repeat (30) @(posedge clock);
            `CHK("otherSource", 0, convCount)
            pulse(5);
            repeat (40) @(posedge clock);
            `CHK("ownSource", 1, convCount)
            rd(`ADCSQ_OFF_STAT, d);
            `CHK("trgFlag", 1'b1, d[3])
            pulse(5);
            repeat (40) @(posedge clock);
            `CHK("onceOnly", 1, convCount)
            wr(`ADCSQ_OFF_STAT, 32'h1c);
            rd(`ADCSQ_OFF_STAT, d);
            `CHK("trgClear", 1'b0, d[3])
        end
    endtask
    task automatic t_ctl();
        int n;
        wr(`ADCSQ_OFF_MODE, 32'h10);
        go();
        repeat (40) @(posedge clock);
        `CHK("noEnable", 0, convCount)
        wr(`ADCSQ_OFF_MODE, 32'hd0);
        go();
        repeat (100) @(posedge clock);
        `CHK("restart", 1'b1, convCount >= 3)
        wr(`ADCSQ_OFF_CTRL, 32'h80);
        waitIdle();
        n = convCount;
        repeat (60) @(posedge clock);
        `CHK("halted", n, convCount)
        rd(`ADCSQ_OFF_CTRL, d);
        `CHK("selfClear", 2'b00, {d[7], d[0]})
        wr(`ADCSQ_OFF_CLK, 32'h100);
        wr(`ADCSQ_OFF_MODE, 32'h90);
        go();
        repeat (60) @(posedge clock);
        `CHK("clockStopped", 0, convCount)
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_dma();
        t_seq(0);
        t_seq(2);
        t_seq(7);
        t_redirect();
        t_events();
        t_ctl();
        summarize();
    end
endmodule
`default_nettype wire
